// ### design/dtf_params.svh
// Purpose: Constants of the disk task-file register block.
// Assumes: A 50 MHz system clock.
// Notes: Offsets are the host I/O addresses of each register.
`ifndef DTF_PARAMS_SVH
`define DTF_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DTF_OFF_DATA 10'h1F0
`define DTF_OFF_ERR 10'h1F1
`define DTF_OFF_SCNT 10'h1F2
`define DTF_OFF_SNUM 10'h1F3
`define DTF_OFF_CYLL 10'h1F4
`define DTF_OFF_CYLH 10'h1F5
`define DTF_OFF_DH 10'h1F6
`define DTF_OFF_STAT 10'h1F7
`define DTF_OFF_ALT 10'h3F6
`define DTF_OFF_DADR 10'h3F7
`define DTF_BASE_CMD 7'h3E
`define DTF_BASE_CTL 7'h7E
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DTF_ST_BUSY 7
`define DTF_ST_RDY 6
`define DTF_ST_WF 5
`define DTF_ST_DSC 4
`define DTF_ST_DRQ 3
`define DTF_ST_CORRECTED_DATA_FLAG 2
`define DTF_ST_IDX 1
`define DTF_ST_ERR 0
`define DTF_ER_ABORTED_COMMAND 2
`define DTF_ER_MASK 8'hD7
`define DTF_DC_SOFTWARE_RESET_BIT 2
`define DTF_DC_INTERRUPT_DISABLE_BIT 1
`define DTF_DH_LBA 6
`define DTF_DH_DEV 4
`define DTF_OE_WORD 16'hFFFF
`define DTF_OE_BYTE 16'h00FF
`define DTF_OE_DADR 16'h007F
// ----------------------------------------
// Reset values and command codes
// ----------------------------------------
`define DTF_DIAG_OK 8'h01
`define DTF_DH_RST 8'hA0
`define DTF_SC_RST 8'h01
`define DTF_SN_RST 8'h01
`define DTF_CMD_DIAG 8'h90
`define DTF_CMD_INIT 8'h91
// ----------------------------------------
// Timing
// ----------------------------------------
`define DTF_CLK_MHZ 50
`define DTF_BUSY_NS 400
`define DTF_BUSY_CYC ((`DTF_BUSY_NS * `DTF_CLK_MHZ) / 1000)
`endif

// ### design/dtf_pkg.sv
// Purpose: Types of the disk task-file register block.
// Assumes: Constants come from dtf_params.svh.
// Notes: Host pins travel as one struct through the synchroniser.
package dtf_pkg;

  typedef struct packed {
    logic cs1_n;
    logic cs3_n;
    logic [2:0] da;
    logic dior_n;
    logic diow_n;
    logic dev;
    logic [15:0] dd;
  } dtf_pins_t;

  typedef struct packed {
    logic ready;
    logic wfault;
    logic seek_done;
    logic corrected_data_flag;
    logic idx;
    logic wgate;
  } dtf_core_stat_t;

  typedef struct packed {
    logic diag;
    logic err;
    logic [7:0] code;
    logic [7:0] sc;
    logic [7:0] sn;
    logic [7:0] cl;
    logic [7:0] ch;
    logic [3:0] head;
  } dtf_core_res_t;

  typedef struct packed {
    logic [7:0] feat;
    logic [8:0] scnt;
    logic [7:0] snum;
    logic [15:0] cyl;
    logic lba;
    logic dev;
    logic [3:0] head;
  } dtf_task_file_t;

  typedef enum logic [3:0] {
    RS_NONE = 4'h0,
    RS_DATA = 4'h1,
    RS_ERR = 4'h2,
    RS_SCNT = 4'h3,
    RS_SNUM = 4'h4,
    RS_CYLL = 4'h5,
    RS_CYLH = 4'h6,
    RS_DH = 4'h7,
    RS_STAT = 4'h8,
    RS_ALT = 4'h9,
    RS_DADR = 4'hA
  } dtf_reg_sel_t;

endpackage : dtf_pkg

// ### design/dtf_task_file.sv
// Purpose: Task-file registers behind the parallel host port of a disk drive.
// Assumes: Host pins are asynchronous; the drive core runs on clk_sys_i.
// Notes: Strobes are sampled, so host cycles must span several clocks.
`timescale 1ns/1ps
`include "dtf_params.svh"

module dtf_task_file (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Host port pins
  input wire logic cs1_n_i,
  input wire logic cs3_n_i,
  input wire logic [2:0] da_i,
  input wire logic dior_n_i,
  input wire logic diow_n_i,
  input wire logic [15:0] dd_i,
  output logic [15:0] dd_o,
  output logic [15:0] dd_oe_o,
  output logic intrq_o,
  output logic intrq_oe_o,
  // Device number strap
  input wire logic dev_strap_i,
  // Drive core side
  input wire dtf_pkg::dtf_core_stat_t core_stat_i,
  input wire logic core_drq_i,
  input wire logic core_blk_i,
  input wire logic core_done_i,
  input wire dtf_pkg::dtf_core_res_t core_res_i,
  input wire logic [15:0] core_rdata_i,
  output logic cmd_start_o,
  output logic [7:0] cmd_code_o,
  output dtf_pkg::dtf_task_file_t task_file_o,
  output logic [3:0] heads_m1_o,
  output logic data_wr_o,
  output logic data_rd_o,
  output logic [15:0] data_wdata_o,
  output logic software_reset_bit_o
);

  localparam int BUSY_CYC = `DTF_BUSY_CYC;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic dtf_pkg::dtf_reg_sel_t reg_of(input logic cs1_n, input logic cs3_n,
                                                   input logic [2:0] da);
    logic [9:0] a;
    a = {(!cs1_n ? `DTF_BASE_CMD : `DTF_BASE_CTL), da};
    if (cs1_n == cs3_n) begin
      reg_of = dtf_pkg::RS_NONE;
    end else if (a == `DTF_OFF_DATA) begin
      reg_of = dtf_pkg::RS_DATA;
    end else if (a == `DTF_OFF_ERR) begin
      reg_of = dtf_pkg::RS_ERR;
    end else if (a == `DTF_OFF_SCNT) begin
      reg_of = dtf_pkg::RS_SCNT;
    end else if (a == `DTF_OFF_SNUM) begin
      reg_of = dtf_pkg::RS_SNUM;
    end else if (a == `DTF_OFF_CYLL) begin
      reg_of = dtf_pkg::RS_CYLL;
    end else if (a == `DTF_OFF_CYLH) begin
      reg_of = dtf_pkg::RS_CYLH;
    end else if (a == `DTF_OFF_DH) begin
      reg_of = dtf_pkg::RS_DH;
    end else if (a == `DTF_OFF_STAT) begin
      reg_of = dtf_pkg::RS_STAT;
    end else if (a == `DTF_OFF_ALT) begin
      reg_of = dtf_pkg::RS_ALT;
    end else if (a == `DTF_OFF_DADR) begin
      reg_of = dtf_pkg::RS_DADR;
    end else begin
      reg_of = dtf_pkg::RS_NONE;
    end
  endfunction : reg_of

  function automatic logic in_cmd_blk(input dtf_pkg::dtf_reg_sel_t s);
    in_cmd_blk = (s != dtf_pkg::RS_NONE) && (s < dtf_pkg::RS_ALT);
  endfunction : in_cmd_blk

  // Codes the drive accepts; anything else is aborted.
  function automatic logic cmd_known(input logic [7:0] c);
    casez (c)
      8'h1?, 8'h7?, 8'h20, 8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32, 8'h33,
      8'h40, 8'h41, 8'h50, 8'h90, 8'h91, 8'h92, 8'h94, 8'h95, 8'h96, 8'h97,
      8'h98, 8'h99, 8'hB0, 8'hC4, 8'hC5, 8'hC6, 8'hC8, 8'hC9, 8'hCA, 8'hCB,
      8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hEC,
      8'hEF, 8'hF8, 8'hF9: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction : cmd_known

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  dtf_pkg::dtf_pins_t pin_s1_r;
  dtf_pkg::dtf_pins_t pin_s2_r;
  dtf_pkg::dtf_pins_t pin_s3_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_s1_r <= dtf_pkg::dtf_pins_t'('1);
      pin_s2_r <= dtf_pkg::dtf_pins_t'('1);
      pin_s3_r <= dtf_pkg::dtf_pins_t'('1);
    end else begin
      pin_s1_r <= {cs1_n_i, cs3_n_i, da_i, dior_n_i, diow_n_i, dev_strap_i, dd_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // ----------------------------------------
  // Task file state
  // ----------------------------------------
  logic [7:0] feat_r, feat_nxt;
  logic [7:0] sc_r, sc_nxt;
  logic [7:0] sn_r, sn_nxt;
  logic [7:0] cl_r, cl_nxt;
  logic [7:0] ch_r, ch_nxt;
  logic [7:0] dh_r, dh_nxt;
  logic [7:0] err_reg_r, err_reg_nxt;
  logic software_reset_bit_r, software_reset_bit_nxt;
  logic interrupt_disable_bit_r, interrupt_disable_bit_nxt;
  logic busy_r, busy_nxt;
  logic drq_r, drq_nxt;
  logic errb_r, errb_nxt;
  logic int_r, int_nxt;
  logic hold_r, hold_nxt;
  logic [2:0] held_r, held_nxt;
  logic [3:0] heads_r, heads_nxt;
  logic cmd_r, cmd_nxt;
  logic [7:0] code_r, code_nxt;
  logic dwr_r, dwr_nxt;
  logic drd_r, drd_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] dd_r, dd_nxt;
  logic [15:0] oe_r, oe_nxt;
  logic irq_r, irq_nxt;
  logic irq_oe_r, irq_oe_nxt;
  dtf_pkg::dtf_task_file_t tf_r, tf_nxt;

  dtf_pkg::dtf_reg_sel_t sel_now;
  dtf_pkg::dtf_reg_sel_t sel_end;
  logic [7:0] stat;
  logic [2:0] live3;
  logic selected;
  logic rd_act;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  logic stat_ack;
  logic [7:0] wbyte;
  logic cmd_ok;
  logic [15:0] rdval;
  logic [15:0] rdoe;

  always_comb begin
    sel_now = reg_of(pin_s2_r.cs1_n, pin_s2_r.cs3_n, pin_s2_r.da);
    sel_end = reg_of(pin_s3_r.cs1_n, pin_s3_r.cs3_n, pin_s3_r.da);
    selected = (dh_r[`DTF_DH_DEV] == pin_s2_r.dev);
    rd_act = !pin_s2_r.dior_n;
    rd_start = !pin_s2_r.dior_n && pin_s3_r.dior_n;
    rd_end = pin_s2_r.dior_n && !pin_s3_r.dior_n;
    wr_end = pin_s2_r.diow_n && !pin_s3_r.diow_n;
    wbyte = pin_s3_r.dd[7:0];
    stat_ack = rd_start && selected && (sel_now == dtf_pkg::RS_STAT);
    live3 = {core_stat_i.ready, core_stat_i.wfault, core_stat_i.seek_done};
    // Status view; frozen flags after an error.
    stat = 8'h00;
    stat[`DTF_ST_BUSY] = busy_r;
    stat[`DTF_ST_RDY] = hold_r ? held_r[2] : live3[2];
    stat[`DTF_ST_WF] = hold_r ? held_r[1] : live3[1];
    stat[`DTF_ST_DSC] = hold_r ? held_r[0] : live3[0];
    stat[`DTF_ST_DRQ] = drq_r;
    stat[`DTF_ST_CORRECTED_DATA_FLAG] = core_stat_i.corrected_data_flag;
    stat[`DTF_ST_IDX] = core_stat_i.idx;
    stat[`DTF_ST_ERR] = errb_r;
    cmd_ok = (cmd_known(wbyte) && live3[2] && !live3[1]) || (wbyte == `DTF_CMD_DIAG);

    // Read multiplexer.
    rdval = 16'h0000;
    rdoe = `DTF_OE_BYTE;
    if (busy_r && in_cmd_blk(sel_now)) begin
      rdval = {8'h00, stat};
    end else if (sel_now == dtf_pkg::RS_DATA) begin
      rdval = core_rdata_i;
      rdoe = `DTF_OE_WORD;
    end else if (sel_now == dtf_pkg::RS_ERR) begin
      rdval = {8'h00, err_reg_r};
    end else if (sel_now == dtf_pkg::RS_SCNT) begin
      rdval = {8'h00, sc_r};
    end else if (sel_now == dtf_pkg::RS_SNUM) begin
      rdval = {8'h00, sn_r};
    end else if (sel_now == dtf_pkg::RS_CYLL) begin
      rdval = {8'h00, cl_r};
    end else if (sel_now == dtf_pkg::RS_CYLH) begin
      rdval = {8'h00, ch_r};
    end else if (sel_now == dtf_pkg::RS_DH) begin
      rdval = {8'h00, dh_r};
    end else if (sel_now == dtf_pkg::RS_STAT || sel_now == dtf_pkg::RS_ALT) begin
      rdval = {8'h00, stat};
    end else if (sel_now == dtf_pkg::RS_DADR) begin
      rdval = {9'h000, !core_stat_i.wgate, ~dh_r[3:0],
               !(selected && pin_s2_r.dev), !(selected && !pin_s2_r.dev)};
      rdoe = `DTF_OE_DADR;
    end else begin
      rdoe = 16'h0000;
    end
    dd_nxt = 16'h0000;
    oe_nxt = 16'h0000;
    if (rd_act && selected) begin
      dd_nxt = rdval;
      oe_nxt = rdoe;
    end

    // Defaults.
    feat_nxt = feat_r;
    sc_nxt = sc_r;
    sn_nxt = sn_r;
    cl_nxt = cl_r;
    ch_nxt = ch_r;
    dh_nxt = dh_r;
    err_reg_nxt = err_reg_r;
    software_reset_bit_nxt = software_reset_bit_r;
    interrupt_disable_bit_nxt = interrupt_disable_bit_r;
    busy_nxt = busy_r;
    drq_nxt = drq_r;
    errb_nxt = errb_r;
    int_nxt = int_r;
    hold_nxt = hold_r;
    held_nxt = held_r;
    heads_nxt = heads_r;
    cmd_nxt = 1'b0;
    code_nxt = code_r;
    dwr_nxt = 1'b0;
    drd_nxt = rd_end && selected && (sel_end == dtf_pkg::RS_DATA) && !busy_r;
    wdata_nxt = wdata_r;

    // Acknowledge first, so a same-cycle event below wins.
    if (stat_ack) begin
      int_nxt = 1'b0;
      hold_nxt = 1'b0;
    end

    // Host writes.
    if (wr_end) begin
      if (sel_end == dtf_pkg::RS_ALT) begin
        software_reset_bit_nxt = pin_s3_r.dd[`DTF_DC_SOFTWARE_RESET_BIT];
        interrupt_disable_bit_nxt = pin_s3_r.dd[`DTF_DC_INTERRUPT_DISABLE_BIT];
      end else if (sel_end == dtf_pkg::RS_DATA && selected) begin
        dwr_nxt = 1'b1;
        wdata_nxt = pin_s3_r.dd;
      end else if (in_cmd_blk(sel_end) && !busy_r) begin
        if (sel_end == dtf_pkg::RS_ERR) begin
          feat_nxt = wbyte;
        end else if (sel_end == dtf_pkg::RS_SCNT) begin
          sc_nxt = wbyte;
        end else if (sel_end == dtf_pkg::RS_SNUM) begin
          sn_nxt = wbyte;
        end else if (sel_end == dtf_pkg::RS_CYLL) begin
          cl_nxt = wbyte;
        end else if (sel_end == dtf_pkg::RS_CYLH) begin
          ch_nxt = wbyte;
        end else if (sel_end == dtf_pkg::RS_DH) begin
          dh_nxt = wbyte;
        end else if (sel_end == dtf_pkg::RS_STAT && (selected || wbyte == `DTF_CMD_DIAG)) begin
          if (cmd_ok) begin
            cmd_nxt = 1'b1;
            code_nxt = wbyte;
            busy_nxt = 1'b1;
            drq_nxt = 1'b0;
            errb_nxt = 1'b0;
            if (wbyte == `DTF_CMD_INIT) begin
              heads_nxt = dh_r[3:0];
            end
          end else begin
            errb_nxt = 1'b1;
            err_reg_nxt = 8'h00;
            err_reg_nxt[`DTF_ER_ABORTED_COMMAND] = 1'b1;
            int_nxt = 1'b1;
            hold_nxt = 1'b1;
            held_nxt = (hold_r && !stat_ack) ? held_r : live3;
          end
        end
      end
    end

    // Drive core events.
    if (core_blk_i) begin
      drq_nxt = 1'b0;
      busy_nxt = 1'b1;
    end
    if (core_drq_i) begin
      drq_nxt = 1'b1;
      busy_nxt = 1'b0;
      int_nxt = 1'b1;
    end
    if (core_done_i) begin
      busy_nxt = 1'b0;
      drq_nxt = 1'b0;
      int_nxt = 1'b1;
      errb_nxt = core_res_i.err;
      err_reg_nxt = core_res_i.diag ? core_res_i.code : (core_res_i.code & `DTF_ER_MASK);
      sc_nxt = core_res_i.sc;
      sn_nxt = core_res_i.sn;
      cl_nxt = core_res_i.cl;
      ch_nxt = core_res_i.ch;
      dh_nxt[3:0] = core_res_i.head;
      if (core_res_i.err) begin
        hold_nxt = 1'b1;
        held_nxt = (hold_r && !stat_ack) ? held_r : live3;
      end
    end

    // Software reset overrides the task-file registers, status, interrupt and the command and write strobes while the bit stays set.
    if (software_reset_bit_r) begin
      feat_nxt = 8'h00;
      sc_nxt = `DTF_SC_RST;
      sn_nxt = `DTF_SN_RST;
      cl_nxt = 8'h00;
      ch_nxt = 8'h00;
      dh_nxt = `DTF_DH_RST;
      err_reg_nxt = `DTF_DIAG_OK;
      busy_nxt = 1'b1;
      drq_nxt = 1'b0;
      errb_nxt = 1'b0;
      int_nxt = 1'b0;
      hold_nxt = 1'b0;
      cmd_nxt = 1'b0;
      dwr_nxt = 1'b0;
    end

    irq_nxt = int_r && !interrupt_disable_bit_r;
    irq_oe_nxt = !interrupt_disable_bit_r && selected;
    tf_nxt.feat = feat_r;
    tf_nxt.scnt = (sc_r == 8'h00) ? 9'h100 : {1'b0, sc_r};
    tf_nxt.snum = sn_r;
    tf_nxt.cyl = {ch_r, cl_r};
    tf_nxt.lba = dh_r[`DTF_DH_LBA];
    tf_nxt.dev = dh_r[`DTF_DH_DEV];
    tf_nxt.head = dh_r[3:0];
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      feat_r <= 8'h00;
      sc_r <= `DTF_SC_RST;
      sn_r <= `DTF_SN_RST;
      cl_r <= 8'h00;
      ch_r <= 8'h00;
      dh_r <= `DTF_DH_RST;
      err_reg_r <= `DTF_DIAG_OK;
      software_reset_bit_r <= 1'b0;
      interrupt_disable_bit_r <= 1'b0;
      busy_r <= 1'b1;
      drq_r <= 1'b0;
      errb_r <= 1'b0;
      int_r <= 1'b0;
      hold_r <= 1'b0;
      held_r <= 3'h0;
      heads_r <= 4'h0;
      cmd_r <= 1'b0;
      code_r <= 8'h00;
      dwr_r <= 1'b0;
      drd_r <= 1'b0;
      wdata_r <= 16'h0000;
      dd_r <= 16'h0000;
      oe_r <= 16'h0000;
      irq_r <= 1'b0;
      irq_oe_r <= 1'b0;
      tf_r <= '0;
    end else begin
      feat_r <= feat_nxt;
      sc_r <= sc_nxt;
      sn_r <= sn_nxt;
      cl_r <= cl_nxt;
      ch_r <= ch_nxt;
      dh_r <= dh_nxt;
      err_reg_r <= err_reg_nxt;
      software_reset_bit_r <= software_reset_bit_nxt;
      interrupt_disable_bit_r <= interrupt_disable_bit_nxt;
      busy_r <= busy_nxt;
      drq_r <= drq_nxt;
      errb_r <= errb_nxt;
      int_r <= int_nxt;
      hold_r <= hold_nxt;
      held_r <= held_nxt;
      heads_r <= heads_nxt;
      cmd_r <= cmd_nxt;
      code_r <= code_nxt;
      dwr_r <= dwr_nxt;
      drd_r <= drd_nxt;
      wdata_r <= wdata_nxt;
      dd_r <= dd_nxt;
      oe_r <= oe_nxt;
      irq_r <= irq_nxt;
      irq_oe_r <= irq_oe_nxt;
      tf_r <= tf_nxt;
    end
  end

  assign dd_o = dd_r;
  assign dd_oe_o = oe_r;
  assign intrq_o = irq_r;
  assign intrq_oe_o = irq_oe_r;
  assign cmd_start_o = cmd_r;
  assign cmd_code_o = code_r;
  assign task_file_o = tf_r;
  assign heads_m1_o = heads_r;
  assign data_wr_o = dwr_r;
  assign data_rd_o = drd_r;
  assign data_wdata_o = wdata_r;
  assign software_reset_bit_o = software_reset_bit_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_alt_keeps_irq: assert property (
    (rd_start && sel_now == dtf_pkg::RS_ALT && int_r && !wr_end && !software_reset_bit_r) |=> int_r)
    else $error("Shadow status read dropped the pending interrupt.");

  a_dadr_head: assert property (
    (rd_act && selected && sel_now == dtf_pkg::RS_DADR) |=> (dd_o[5:2] == ~$past(dh_r[3:0])))
    else $error("Drive address head bits are not the inverted head.");

  a_dadr_undriven: assert property (
    (sel_now == dtf_pkg::RS_DADR) |=> !dd_oe_o[7])
    else $error("Drive address bit 7 was driven.");

  a_software_reset_bit_busy: assert property (
    software_reset_bit_r [*2] |-> busy_r && !int_r)
    else $error("Software reset did not hold the drive busy.");

  a_irq_disabled: assert property (
    interrupt_disable_bit_r [*2] |-> !intrq_oe_o && !intrq_o)
    else $error("Interrupt line driven while disabled.");

  a_err_mask: assert property (
    (core_done_i && !core_res_i.diag && !software_reset_bit_r) |=> (err_reg_r[5] == 1'b0) && (err_reg_r[3] == 1'b0))
    else $error("Unused error bits set.");

  a_scnt_zero: assert property (
    (sc_r == 8'h00) |=> (task_file_o.scnt == 9'h100))
    else $error("Sector count zero not shown as 256.");

  a_stat_ack: assert property (
    (stat_ack && !core_done_i && !core_drq_i && !wr_end) |=> !int_r)
    else $error("Status read did not clear the interrupt.");

  a_busy_mirror: assert property (
    (busy_r && rd_act && selected && in_cmd_blk(sel_now)) |=> (dd_o[7:0] == $past(stat)))
    else $error("Busy read did not return status.");

  a_cmd_busy: assert property (
    $rose(cmd_start_o) |-> ##[0:BUSY_CYC] busy_r)
    else $error("Busy not set after a command.");

  a_hold_flags: assert property (
    (hold_r && !stat_ack && !software_reset_bit_r) |=> (stat[6:4] == $past(held_r)))
    else $error("Frozen status flags changed before a status read.");

endmodule : dtf_task_file

// ### tb/dtf_host_model.sv
// Purpose: Host controller model that runs task-file register cycles.
// Assumes: Pins change at the falling clock edge.
// Notes: Each strobe phase spans five clocks, longer than the pin pipe.
`timescale 1ns/1ps
`include "dtf_params.svh"
module dtf_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Wire level and drive enables seen from the host
  input wire logic [15:0] dd_i,
  input wire logic [15:0] oe_i,
  // Host pins
  output logic cs1_n_o,
  output logic cs3_n_o,
  output logic [2:0] da_o,
  output logic dior_n_o,
  output logic diow_n_o,
  output logic [15:0] dd_o,
  output logic dd_en_o
);
  initial begin
    {cs1_n_o, cs3_n_o, dior_n_o, diow_n_o} = 4'hF;
    da_o = 3'h0;
    dd_o = 16'h0000;
    dd_en_o = 1'b0;
  end
  task automatic sel(input logic [9:0] a);
    cs1_n_o = (a[9:3] != `DTF_BASE_CMD);
    cs3_n_o = (a[9:3] != `DTF_BASE_CTL);
    da_o = a[2:0];
  endtask : sel
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    sel(a);
    dd_o = d;
    dd_en_o = 1'b1;
    diow_n_o = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    diow_n_o = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    dd_en_o = 1'b0;
    sel(10'h000);
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic [15:0] o);
    @(negedge clk_sys_i);
    sel(a);
    dior_n_o = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    d = dd_i;
    o = oe_i;
    dior_n_o = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    sel(10'h000);
  endtask : rd
endmodule : dtf_host_model

// ### tb/dtf_task_file_tb.sv
// Purpose: Self-checking bench of the task-file register block.
// Assumes: One drive strapped as device 0, always ready.
// Notes: Undriven data bits toggle each clock, so stale data cannot pass.
`timescale 1ns/1ps
`include "dtf_params.svh"
module dtf_task_file_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] dd_o, dd_oe_o, hd, dd_w, d, o, e, x16;
  logic [15:0] rdata = 16'h0000;
  logic [15:0] pat = 16'h5A5A;
  logic hen, cs1_n, cs3_n, dior_n, diow_n, intrq_o, intrq_oe_o, software_reset_bit_o;
  logic cmd_start_o, data_wr_o, data_rd_o;
  logic data_request_flag = 1'b0;
  logic blk = 1'b0;
  logic done = 1'b0;
  logic [2:0] da;
  logic [7:0] cmd_code_o, r;
  logic [3:0] heads_m1_o;
  dtf_pkg::dtf_core_stat_t cst = 6'h28;
  dtf_pkg::dtf_core_res_t cres = '0;
  dtf_pkg::dtf_task_file_t tf;
  logic [7:0] mdl [logic [9:0]];
  int miscompares = 0;
  int n_tests = 0;
  int nst = 0;
  int nwr = 0;
  int nrd = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    pat <= ~pat;
    nst <= nst + int'(cmd_start_o === 1'b1);
    nwr <= nwr + int'(data_wr_o === 1'b1);
    nrd <= nrd + int'(data_rd_o === 1'b1);
  end
  // A released line never keeps its last value.
  assign dd_w = hen ? hd : ((dd_oe_o & dd_o) | (~dd_oe_o & pat));
  dtf_host_model h (.clk_sys_i(clk_sys_i), .dd_i(dd_w), .oe_i(dd_oe_o), .cs1_n_o(cs1_n),
    .cs3_n_o(cs3_n), .da_o(da), .dior_n_o(dior_n), .diow_n_o(diow_n), .dd_o(hd), .dd_en_o(hen));
  dtf_task_file dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs1_n_i(cs1_n), .cs3_n_i(cs3_n),
    .da_i(da), .dior_n_i(dior_n), .diow_n_i(diow_n), .dd_i(dd_w), .dd_o(dd_o), .dd_oe_o(dd_oe_o),
    .intrq_o(intrq_o), .intrq_oe_o(intrq_oe_o), .dev_strap_i(1'b0), .core_stat_i(cst),
    .core_drq_i(data_request_flag), .core_blk_i(blk), .core_done_i(done), .core_res_i(cres),
    .core_rdata_i(rdata), .cmd_start_o(cmd_start_o), .cmd_code_o(cmd_code_o),
    .task_file_o(tf), .heads_m1_o(heads_m1_o), .data_wr_o(data_wr_o), .data_rd_o(data_rd_o),
    .data_wdata_o(), .software_reset_bit_o(software_reset_bit_o));
  task automatic close_out;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] g, input logic [15:0] w);
    n_tests++;
    if (g !== w) begin
      $display("unexpected %0t got %h want %h", $time, g, w);
      miscompares++;
    end
  endtask : chk
  task automatic rb(input logic [9:0] a, input logic [7:0] w);
    logic [15:0] v, m;
    h.rd(a, v, m);
    chk({8'h00, v[7:0]}, {8'h00, w});
    chk(m, `DTF_OE_BYTE);
  endtask : rb
  task automatic w(input logic [9:0] a, input logic [15:0] v);
    if (mdl.exists(a)) mdl[a] = v[7:0];
    h.wr(a, v);
  endtask : w
  function automatic logic [7:0] sx(input logic q, input logic er);
    return {1'b0, cst.ready, cst.wfault, cst.seek_done, q, cst.corrected_data_flag, cst.idx, er};
  endfunction : sx
  // Completion loads a fresh disk address with no sectors left.
  task automatic fin(input logic g, input logic er, input logic [7:0] c);
    logic [27:0] x;
    x = 28'($urandom);
    mdl[`DTF_OFF_SCNT] = 8'h00;
    mdl[`DTF_OFF_SNUM] = x[7:0];
    mdl[`DTF_OFF_CYLL] = x[15:8];
    mdl[`DTF_OFF_CYLH] = x[23:16];
    mdl[`DTF_OFF_DH] = {mdl[`DTF_OFF_DH][7:4], x[27:24]};
    @(negedge clk_sys_i);
    cres = {g, er, c, 8'h00, x[7:0], x[15:8], x[23:16], x[27:24]};
    done = 1'b1;
    @(negedge clk_sys_i);
    done = 1'b0;
    repeat (3) @(negedge clk_sys_i);
  endtask : fin
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    miscompares++;
    close_out();
  end
  initial begin
    void'($urandom(32'hA9F7A668));
    mdl[`DTF_OFF_SCNT] = `DTF_SC_RST;
    mdl[`DTF_OFF_SNUM] = `DTF_SN_RST;
    mdl[`DTF_OFF_CYLL] = 8'h00;
    mdl[`DTF_OFF_CYLH] = 8'h00;
    mdl[`DTF_OFF_DH] = `DTF_DH_RST;
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    h.rd(`DTF_OFF_ALT, d, o);
    chk(d[7], 1'b1);
    fin(1'b1, 1'b0, `DTF_DIAG_OK);
    rb(`DTF_OFF_ERR, `DTF_DIAG_OK);
    rb(`DTF_OFF_STAT, sx(1'b0, 1'b0));
    for (int a = `DTF_OFF_SCNT; a <= `DTF_OFF_DH; a++) begin
      r = 8'($urandom);
      w(10'(a), (a == `DTF_OFF_DH) ? (8'hA0 | (r & 8'h4F)) : r);
    end
    for (int a = `DTF_OFF_SCNT; a <= `DTF_OFF_DH; a++) rb(10'(a), mdl[10'(a)]);
    chk(tf.lba, mdl[`DTF_OFF_DH][6]);
    chk(tf.cyl, {mdl[`DTF_OFF_CYLH], mdl[`DTF_OFF_CYLL]});
    chk({tf.snum, tf.head}, {mdl[`DTF_OFF_SNUM], mdl[`DTF_OFF_DH][3:0]});
    x16 = 16'($urandom);
    w(`DTF_OFF_ERR, x16);
    chk(tf.feat, x16[7:0]);
    h.rd(`DTF_OFF_DADR, d, o);
    chk(o, `DTF_OE_DADR);
    chk(d[6:0], {1'b1, ~mdl[`DTF_OFF_DH][3:0], 2'b10});
    w(`DTF_OFF_SCNT, 16'h0000);
    chk(tf.scnt, 9'h100);
    w(`DTF_OFF_STAT, `DTF_CMD_INIT);
    chk(16'(nst), 16'h0001);
    chk(cmd_code_o, `DTF_CMD_INIT);
    chk(heads_m1_o, mdl[`DTF_OFF_DH][3:0]);
    h.rd(`DTF_OFF_ALT, d, o);
    h.rd(`DTF_OFF_SCNT, e, o);
    chk(d[7], 1'b1);
    chk(e[7:0], d[7:0]);
    fin(1'b0, 1'b0, 8'h00);
    chk({intrq_oe_o, intrq_o}, 2'b11);
    rb(`DTF_OFF_ALT, sx(1'b0, 1'b0));
    chk(intrq_o, 1'b1);
    rb(`DTF_OFF_STAT, sx(1'b0, 1'b0));
    chk(intrq_o, 1'b0);
    for (int a = `DTF_OFF_SCNT; a <= `DTF_OFF_DH; a++) rb(10'(a), mdl[10'(a)]);
    w(`DTF_OFF_STAT, 16'h0000);
    chk(16'(nst), 16'h0001);
    rb(`DTF_OFF_ERR, 8'h04);
    r = sx(1'b0, 1'b1);
    cst.wfault = 1'b1;
    rb(`DTF_OFF_ALT, r);
    cst.wfault = 1'b0;
    rb(`DTF_OFF_STAT, sx(1'b0, 1'b1));
    w(`DTF_OFF_STAT, `DTF_CMD_INIT);
    fin(1'b0, 1'b1, 8'hFF);
    rb(`DTF_OFF_ERR, `DTF_ER_MASK);
    w(`DTF_OFF_ALT, 16'h000A);
    chk(intrq_oe_o, 1'b0);
    w(`DTF_OFF_ALT, 16'h0008);
    x16 = 16'($urandom);
    w(`DTF_OFF_DATA, x16);
    chk(dut.data_wdata_o, x16);
    chk(16'(nwr), 16'h0001);
    rdata = 16'($urandom);
    h.rd(`DTF_OFF_DATA, d, o);
    chk(d, rdata);
    chk(o, `DTF_OE_WORD);
    chk(16'(nrd), 16'h0001);
    @(negedge clk_sys_i) data_request_flag = 1'b1;
    @(negedge clk_sys_i) data_request_flag = 1'b0;
    h.rd(`DTF_OFF_ALT, d, o);
    chk(d[7:3] & 5'h11, 5'h01);
    @(negedge clk_sys_i) blk = 1'b1;
    @(negedge clk_sys_i) blk = 1'b0;
    h.rd(`DTF_OFF_ALT, d, o);
    chk(d[7:3] & 5'h11, 5'h10);
    w(`DTF_OFF_ALT, 16'h000C);
    chk(software_reset_bit_o, 1'b1);
    w(`DTF_OFF_ALT, 16'h0008);
    h.rd(`DTF_OFF_ALT, d, o);
    chk(d[7], 1'b1);
    fin(1'b1, 1'b0, `DTF_DIAG_OK);
    rb(`DTF_OFF_ERR, `DTF_DIAG_OK);
    h.rd(10'h3F0, d, o);
    chk(o, 16'h0000);
    close_out();
  end
endmodule : dtf_task_file_tb
